// ==== core/cpu_test_xor_and_ext_set.sv ====
// Decode and execute slice: skip-if-zero, exclusive-OR, extended pointer ops
// Summary of operation
// RQ1 - A skip-if-zero that finds its file byte at zero discards the fetched next word and runs one no-op cycle.
// RQ2 - When the skipped instruction is two words long the skip costs two no-op cycles, three cycles in all.
// RQ3 - File operations use the access bank when the access bit is 0 and the bank pointer when it is 1.
// RQ4 - With the extension on and access bit 0, file addresses up to 5Fh are offsets from the stack frame pointer.
// RQ5 - The accumulator-with-file exclusive-OR writes the accumulator when d is 0 and the file byte when d is 1.
// RQ6 - That exclusive-OR updates only the negative and zero flags.
// RQ7 - That exclusive-OR is decoded from opcode bits 0001 10da with an eight-bit file address.
// RQ8 - The extension adds eight opcodes for indirect and indexed work plus indexed literal offset addressing.
// RQ9 - The extension enable reads as on after reset until software sets or clears it.
// RQ10 - Pointer add and subtract with field 3 act on the stack frame pointer and then return.
// RQ11 - Every extended opcode except CALLW, which has no literal field, is a literal operation on a file-select pointer or through one.
// RQ12 - The base set stands unchanged without the extension; with it, access-bank file addresses up to 5Fh become stack frame pointer offsets.
// RQ13 - The literal exclusive-OR writes the accumulator in one cycle and updates negative and zero.
// RQ14 - The skip-if-zero changes no flag and writes no register.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_xor_test_map.svh"
module cpu_test_xor_and_ext_set (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	// Data memory
	output logic      [11:0] dmem_addr,
	output logic      [7:0]  dmem_wdata,
	output logic             dmem_we,
	output logic             dmem_re,
	input  wire logic [7:0]  dmem_rdata,
	// Return stack
	output logic             ret_pop
);
	import cpu_xor_test_pkg::*;

	state_t      st;
	state_t      nx;
	logic [11:0] ea;
	logic        ea_idx;
	logic        acc_phase;

	function automatic kind_t decode_op(input logic [15:0] op, input logic ext);
		kind_t k;
		k = K_BASE_OTHER; // RQ12
		if (op[15:8] == `OP_XOR_LITERAL_ACC) begin
			k = K_XOR_LITERAL_ACC; // RQ13
		end else if (op[15:10] == `OP_XOR_ACC_WITH_FILE) begin
			k = K_XOR_ACC_WITH_FILE; // RQ7
		end else if (op[15:9] == `OP_TST) begin
			k = K_TST; // RQ1
		end else if (ext && op[15:8] == `OP_ADD_LITERAL_TO_POINTER) begin
			k = (op[7:6] == `FSR_ULNK) ? K_ULNK_ADD : K_FSR_ADD; // RQ10
		end else if (ext && op[15:8] == `OP_SUB_LITERAL_FROM_POINTER) begin
			k = (op[7:6] == `FSR_ULNK) ? K_ULNK_SUB : K_FSR_SUB; // RQ10
		end else if (ext && (op[15:8] == `OP_PUSHL || op[15:8] == `OP_MOVSX
				|| op == `OP_CALLW)) begin
			k = K_EXT_OTHER; // RQ8
		end
		return k;
	endfunction : decode_op

	function automatic logic is_file_op(input kind_t k);
		return (k == K_XOR_ACC_WITH_FILE) || (k == K_TST);
	endfunction : is_file_op

	eff_addr_unit u_ea (
		.f       (st.op[7:0]),
		.a       (st.op[8]),
		.bank_select_pointer     (st.bank_select_pointer),
		.stack_frame_pointer    (st.file_select_pointer[2]),
		.ext     (st.ext),
		.addr    (ea),
		.indexed (ea_idx)
	);

	assign acc_phase = hsel && htrans[`HTRANS_NONSEQ_BIT] && hready;

	always_comb begin
		nx = st;
		nx.dmem_we = 1'b0;
		nx.dmem_re = 1'b0;
		nx.ret_pop = 1'b0;
		nx.hready = 1'b1;

		// Bus address phase and read answer
		nx.dp_wr = acc_phase && hwrite;
		nx.dp_off = haddr[7:0];
		if (acc_phase && !hwrite) begin
			if (haddr[7:0] == `OFF_INSTR) begin
				nx.hrdata = {16'h0000, st.op};
			end else if (haddr[7:0] == `OFF_CTRL) begin
				nx.hrdata = 32'h0000_0000;
				nx.hrdata[`CTRL_TWO_WORD] = st.two_word;
				nx.hrdata[`CTRL_EXT] = st.ext; // RQ9
			end else if (haddr[7:0] == `OFF_WREG) begin
				nx.hrdata = {24'h00_0000, st.w};
			end else if (haddr[7:0] == `OFF_FLAGS) begin
				nx.hrdata = 32'h0000_0000;
				nx.hrdata[`FLAG_N] = st.n;
				nx.hrdata[`FLAG_Z] = st.z;
			end else if (haddr[7:0] == `OFF_BANK) begin
				nx.hrdata = {28'h000_0000, st.bank_select_pointer};
			end else if (haddr[7:0] == `OFF_FSR0) begin
				nx.hrdata = {20'h0_0000, st.file_select_pointer[0]};
			end else if (haddr[7:0] == `OFF_FSR1) begin
				nx.hrdata = {20'h0_0000, st.file_select_pointer[1]};
			end else if (haddr[7:0] == `OFF_STACK_FRAME_POINTER) begin
				nx.hrdata = {20'h0_0000, st.file_select_pointer[2]};
			end else if (haddr[7:0] == `OFF_TRACE) begin
				nx.hrdata = {20'h0_0000, st.addr};
				nx.hrdata[`TR_CYC_LO+1:`TR_CYC_LO] = st.cycles;
				nx.hrdata[`TR_BUSY] = st.busy;
				nx.hrdata[`TR_SKIP] = st.skipped;
				nx.hrdata[`TR_UNHANDLED] = st.unhandled;
				nx.hrdata[`TR_INDEXED] = st.indexed;
			end else begin
				nx.hrdata = 32'h0000_0000;
			end
		end

		// Bus data phase writes, taken only while idle
		if (st.dp_wr && !st.busy) begin
			if (st.dp_off == `OFF_INSTR) begin
				nx.op = hwdata[15:0];
				nx.busy = 1'b1;
				nx.nop = 1'b0;
				nx.q = `PH_Q1;
				nx.extra = 2'h0;
				nx.cycles = 2'h0;
				nx.skipped = 1'b0;
				nx.unhandled = 1'b0;
				nx.indexed = 1'b0;
				nx.kind = K_NONE;
			end else if (st.dp_off == `OFF_CTRL) begin
				nx.two_word = hwdata[`CTRL_TWO_WORD];
				nx.ext = hwdata[`CTRL_EXT]; // RQ9
			end else if (st.dp_off == `OFF_WREG) begin
				nx.w = hwdata[7:0];
			end else if (st.dp_off == `OFF_FLAGS) begin
				nx.n = hwdata[`FLAG_N];
				nx.z = hwdata[`FLAG_Z];
			end else if (st.dp_off == `OFF_BANK) begin
				nx.bank_select_pointer = hwdata[3:0];
			end else if (st.dp_off == `OFF_FSR0) begin
				nx.file_select_pointer[0] = hwdata[11:0];
			end else if (st.dp_off == `OFF_FSR1) begin
				nx.file_select_pointer[1] = hwdata[11:0];
			end else if (st.dp_off == `OFF_STACK_FRAME_POINTER) begin
				nx.file_select_pointer[2] = hwdata[11:0];
			end
		end

		// Four-phase instruction cycle
		if (st.busy) begin
			nx.q = st.q + 2'h1;
			if (st.nop) begin
				if (st.q == `PH_Q4) begin
					nx.cycles = st.cycles + 2'h1;
					nx.extra = st.extra - 2'h1;
					if (st.extra == `NOP_ONE) begin
						nx.busy = 1'b0;
						nx.nop = 1'b0;
					end
				end
			end else begin
				case (st.q)
					`PH_Q1: begin
						nx.kind = decode_op(st.op, st.ext);
					end
					`PH_Q2: begin
						if (is_file_op(st.kind)) begin
							nx.dmem_addr = ea; // RQ3
							nx.dmem_re = 1'b1;
							nx.addr = ea;
							nx.indexed = ea_idx; // RQ4
						end
					end
					`PH_Q3: begin
						case (st.kind)
							K_XOR_LITERAL_ACC: begin
								nx.res = st.w ^ st.op[7:0]; // RQ13
							end
							K_XOR_ACC_WITH_FILE: begin
								nx.res = st.w ^ dmem_rdata;
								if (st.op[9]) begin
									nx.dmem_wdata = st.w ^ dmem_rdata; // RQ5
									nx.dmem_we = 1'b1; // RQ5
								end
							end
							K_TST: begin // RQ14
								if (dmem_rdata == 8'h00) begin
									nx.skipped = 1'b1; // RQ1
									nx.extra = st.two_word ? `NOP_TWO : `NOP_ONE; // RQ2
								end
							end
							K_FSR_ADD: begin
								nx.file_select_pointer[st.op[7:6]] = st.file_select_pointer[st.op[7:6]] + {6'h00, st.op[5:0]}; // RQ11
							end
							K_FSR_SUB: begin
								nx.file_select_pointer[st.op[7:6]] = st.file_select_pointer[st.op[7:6]] - {6'h00, st.op[5:0]}; // RQ11
							end
							K_ULNK_ADD: begin
								nx.file_select_pointer[2] = st.file_select_pointer[2] + {6'h00, st.op[5:0]}; // RQ10
								nx.extra = `NOP_ONE;
							end
							K_ULNK_SUB: begin
								nx.file_select_pointer[2] = st.file_select_pointer[2] - {6'h00, st.op[5:0]}; // RQ10
								nx.extra = `NOP_ONE;
							end
							K_EXT_OTHER, K_BASE_OTHER: begin
								nx.unhandled = 1'b1; // RQ12
							end
							default: begin
								nx.res = st.res;
							end
						endcase
					end
					default: begin
						// Q4: write back; the skip test writes nothing
						if (st.kind == K_XOR_LITERAL_ACC || (st.kind == K_XOR_ACC_WITH_FILE && !st.op[9])) begin
							nx.w = st.res; // RQ5
						end
						if (st.kind == K_XOR_LITERAL_ACC || st.kind == K_XOR_ACC_WITH_FILE) begin
							nx.n = st.res[7]; // RQ6
							nx.z = (st.res == 8'h00); // RQ6
						end
						if (st.kind == K_ULNK_ADD || st.kind == K_ULNK_SUB) begin
							nx.ret_pop = 1'b1; // RQ10
						end
						nx.cycles = st.cycles + 2'h1;
						if (st.extra == 2'h0) begin
							nx.busy = 1'b0;
						end else begin
							nx.nop = 1'b1; // RQ1
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.ext <= `EXT_RESET;
			st.hready <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	assign hreadyout = st.hready;
	assign hrdata = st.hrdata;
	assign hresp = 1'b0;
	assign dmem_addr = st.dmem_addr;
	assign dmem_wdata = st.dmem_wdata;
	assign dmem_we = st.dmem_we;
	assign dmem_re = st.dmem_re;
	assign ret_pop = st.ret_pop;
endmodule : cpu_test_xor_and_ext_set
`default_nettype wire

// ==== core/cpu_xor_test_map.svh ====
// Register offsets, field positions and opcode patterns of the decode slice
`ifndef CPU_XOR_TEST_MAP_SVH
`define CPU_XOR_TEST_MAP_SVH
`define OFF_INSTR   8'h00
`define OFF_CTRL    8'h04
`define OFF_WREG    8'h08
`define OFF_FLAGS   8'h0C
`define OFF_BANK    8'h10
`define OFF_FSR0    8'h14
`define OFF_FSR1    8'h18
`define OFF_STACK_FRAME_POINTER    8'h1C
`define OFF_TRACE   8'h20
`define CTRL_TWO_WORD 0
`define CTRL_EXT      1
`define EXT_RESET     1'b1
`define FLAG_Z        2
`define FLAG_N        4
`define TR_CYC_LO     12
`define TR_BUSY       16
`define TR_SKIP       17
`define TR_UNHANDLED  18
`define TR_INDEXED    19
`define OP_XOR_LITERAL_ACC   8'h0A
`define OP_XOR_ACC_WITH_FILE   6'h06
`define OP_TST     7'h33
`define OP_ADD_LITERAL_TO_POINTER  8'hE8
`define OP_SUB_LITERAL_FROM_POINTER  8'hE9
`define OP_PUSHL   8'hEA
`define OP_MOVSX   8'hEB
`define OP_CALLW   16'h0014
`define FSR_ULNK   2'h3
`define IDX_LIMIT  8'h5F
`define ACCESS_LO  4'h0
`define ACCESS_HI  4'hF
`define PH_Q1      2'h0
`define PH_Q2      2'h1
`define PH_Q3      2'h2
`define PH_Q4      2'h3
`define NOP_ONE    2'h1
`define NOP_TWO    2'h2
`define HTRANS_NONSEQ_BIT 1
`endif

// ==== core/cpu_xor_test_pkg.sv ====
// Types of the decode slice: instruction kinds and the state record
package cpu_xor_test_pkg;
	typedef enum logic [3:0] {
		K_NONE, K_XOR_LITERAL_ACC, K_XOR_ACC_WITH_FILE, K_TST, K_FSR_ADD, K_FSR_SUB,
		K_ULNK_ADD, K_ULNK_SUB, K_EXT_OTHER, K_BASE_OTHER
	} kind_t;

	typedef struct packed {
		logic              busy;
		logic              nop;
		logic [1:0]        q;
		logic [1:0]        extra;
		logic [1:0]        cycles;
		kind_t             kind;
		logic [15:0]       op;
		logic              two_word;
		logic              ext;
		logic [7:0]        w;
		logic              n;
		logic              z;
		logic [3:0]        bank_select_pointer;
		logic [2:0][11:0]  file_select_pointer;
		logic [7:0]        res;
		logic [11:0]       addr;
		logic              indexed;
		logic              skipped;
		logic              unhandled;
		logic [11:0]       dmem_addr;
		logic [7:0]        dmem_wdata;
		logic              dmem_we;
		logic              dmem_re;
		logic              ret_pop;
		logic              dp_wr;
		logic [7:0]        dp_off;
		logic [31:0]       hrdata;
		logic              hready;
	} state_t;
endpackage : cpu_xor_test_pkg

// ==== core/eff_addr_unit.sv ====
// Data memory address former for byte-oriented file operations
`timescale 1ns/1ps
`default_nettype none
`include "cpu_xor_test_map.svh"
module eff_addr_unit (
	// Operand fields
	input  wire logic [7:0]  f,
	input  wire logic        a,
	// Pointers and mode
	input  wire logic [3:0]  bank_select_pointer,
	input  wire logic [11:0] stack_frame_pointer,
	input  wire logic        ext,
	// Result
	output logic      [11:0] addr,
	output logic             indexed
);
	always_comb begin
		indexed = ext && !a && (f <= `IDX_LIMIT); // RQ4
		if (indexed) begin
			addr = stack_frame_pointer + {4'h0, f}; // RQ4
		end else if (!a) begin
			addr = {(f <= `IDX_LIMIT) ? `ACCESS_LO : `ACCESS_HI, f}; // RQ3
		end else begin
			addr = {bank_select_pointer, f}; // RQ3
		end
	end
endmodule : eff_addr_unit
`default_nettype wire

// ==== sim/cpu_test_xor_and_ext_set_asserts.sv ====
// Checker for bus answer and data memory timing of the decode slice
`timescale 1ns/1ps
`default_nettype none
module cpu_test_xor_and_ext_set_asserts (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Watched outputs
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [11:0] dmem_addr,
	input wire logic        dmem_we,
	input wire logic        dmem_re,
	input wire logic        ret_pop
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	we_after_re_a: assert property ($rose(dmem_we) |-> $past(dmem_re))
		else $error("file write without read one cycle before");
	we_pulse_a: assert property (dmem_we |=> !dmem_we)
		else $error("file write longer than one cycle");
	re_gap_a: assert property (dmem_re |=> !dmem_re [*3])
		else $error("file read again within one instruction cycle");
	addr_hold_a: assert property (dmem_we |-> $stable(dmem_addr))
		else $error("write address differs from read address");
	pop_alone_a: assert property (ret_pop |-> !dmem_we && !dmem_re)
		else $error("return pop during file access");
	pop_pulse_a: assert property (ret_pop |=> !ret_pop)
		else $error("return pop longer than one cycle");
	mem_excl_a: assert property (!(dmem_we && dmem_re))
		else $error("file read and write together");
	cover property (dmem_re ##1 dmem_we);
	cover property (dmem_re ##1 !dmem_we);
	cover property (ret_pop);
endmodule : cpu_test_xor_and_ext_set_asserts
bind cpu_test_xor_and_ext_set cpu_test_xor_and_ext_set_asserts u_cpu_test_xor_and_ext_set_asserts (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
	.dmem_addr(dmem_addr), .dmem_we(dmem_we), .dmem_re(dmem_re), .ret_pop(ret_pop));
`default_nettype wire

// ==== sim/cpu_test_xor_and_ext_set_tb.sv ====
// Self-checking bench for the skip, exclusive-OR and pointer slice
`timescale 1ns/1ps
`default_nettype none
module cpu_test_xor_and_ext_set_tb;
	logic        hclk, hresetn, hwrite, hreadyout, hresp, dmem_we, dmem_re, ret_pop;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [11:0] dmem_addr;
	logic [7:0]  dmem_wdata;
	logic [7:0]  mem [0:4095];
	int          num_errors, num_checks, pops;
	cpu_test_xor_and_ext_set u_cpu_test_xor_and_ext_set (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dmem_addr(dmem_addr),
		.dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re),
		.dmem_rdata(mem[dmem_addr]), .ret_pop(ret_pop));
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// Data memory and return stack
	always @(posedge hclk) begin
		if (dmem_we === 1'b1)
			mem[dmem_addr] <= dmem_wdata;
		if (ret_pop === 1'b1)
			pops++;
	end
	task automatic stop_test;
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] s, input logic [31:0] m, input logic [31:0] e);
		num_checks++;
		if ((s & m) !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, s & m, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(posedge hclk);
				n++;
			end while (hreadyout !== 1'b1 && n < 20);
			if (hreadyout !== 1'b1) begin
				num_errors++;
				stop_test();
			end
			if (p == 0) begin
				htrans <= 2'h0;
				hwdata <= d;
			end
		end
		q = hrdata;
	endtask : bus
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic exec(input logic [15:0] op);
		int n;
		bus(1'b1, 8'h00, {16'h0000, op});
		n = 0;
		do begin
			rd(8'h20);
			n++;
		end while (q[16] !== 1'b0 && n < 40);
		if (q[16] !== 1'b0) begin
			num_errors++;
			stop_test();
		end
	endtask : exec
	task automatic t_reset;
		rd(8'h04);
		chk(q, 32'h0000_0002, 32'h0000_0002);
		rd(8'h40);
		chk(q, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask : t_reset
	task automatic t_xor_literal_acc;
		bus(1'b1, 8'h08, 32'h0000_00B5);
		exec(16'h0AAF);
		chk(q, 32'h0004_3000, 32'h0000_1000);
		rd(8'h08);
		chk(q, 32'hFFFF_FFFF, 32'h0000_001A);
		exec(16'h0A1A);
		rd(8'h0C);
		chk(q, 32'h0000_0014, 32'h0000_0004);
	endtask : t_xor_literal_acc
	task automatic t_xor_acc_with_file;
		bus(1'b1, 8'h04, 32'h0000_0000);
		bus(1'b1, 8'h10, 32'h0000_0002);
		bus(1'b1, 8'h08, 32'h0000_00B5);
		bus(1'b1, 8'h0C, 32'h0000_0014);
		mem[12'h240] = 8'hAF;
		exec(16'h1B40);
		chk(q, 32'h000F_3FFF, 32'h0000_1240);
		chk({24'h00_0000, mem[12'h240]}, 32'h0000_00FF, 32'h0000_001A);
		rd(8'h08);
		chk(q, 32'hFFFF_FFFF, 32'h0000_00B5);
		rd(8'h0C);
		chk(q, 32'h0000_0014, 32'h0000_0000);
		mem[12'hF80] = 8'h0F;
		bus(1'b1, 8'h08, 32'h0000_00F0);
		exec(16'h1880);
		chk(q, 32'h000F_3FFF, 32'h0000_1F80);
		chk({24'h00_0000, mem[12'hF80]}, 32'h0000_00FF, 32'h0000_000F);
		rd(8'h08);
		chk(q, 32'hFFFF_FFFF, 32'h0000_00FF);
		rd(8'h0C);
		chk(q, 32'h0000_0014, 32'h0000_0010);
	endtask : t_xor_acc_with_file
	task automatic t_indexed;
		bus(1'b1, 8'h04, 32'h0000_0002);
		bus(1'b1, 8'h1C, 32'h0000_0300);
		bus(1'b1, 8'h08, 32'h0000_0055);
		mem[12'h310] = 8'h55;
		exec(16'h1A10);
		chk(q, 32'h000F_3FFF, 32'h0008_1310);
		chk({24'h00_0000, mem[12'h310]}, 32'h0000_00FF, 32'h0000_0000);
		exec(16'h665F);
		chk(q, 32'h0008_0FFF, 32'h0008_035F);
		exec(16'h6660);
		chk(q, 32'h0008_0FFF, 32'h0000_0F60);
	endtask : t_indexed
	task automatic t_skip;
		bus(1'b1, 8'h04, 32'h0000_0000);
		bus(1'b1, 8'h08, 32'h0000_0077);
		bus(1'b1, 8'h0C, 32'h0000_0010);
		mem[12'h250] = 8'h01;
		exec(16'h6750);
		chk(q, 32'h000F_3FFF, 32'h0000_1250);
		mem[12'h250] = 8'h00;
		exec(16'h6750);
		chk(q, 32'h000F_3FFF, 32'h0002_2250);
		bus(1'b1, 8'h04, 32'h0000_0001);
		exec(16'h6750);
		chk(q, 32'h000F_3FFF, 32'h0002_3250);
		chk({24'h00_0000, mem[12'h250]}, 32'h0000_00FF, 32'h0000_0000);
		rd(8'h08);
		chk(q, 32'hFFFF_FFFF, 32'h0000_0077);
		rd(8'h0C);
		chk(q, 32'h0000_0014, 32'h0000_0010);
	endtask : t_skip
	task automatic t_ext;
		bus(1'b1, 8'h04, 32'h0000_0002);
		bus(1'b1, 8'h1C, 32'h0000_03FF);
		bus(1'b1, 8'h14, 32'h0000_0100);
		exec(16'hE8A3);
		rd(8'h1C);
		chk(q, 32'hFFFF_FFFF, 32'h0000_0422);
		exec(16'hE905);
		rd(8'h14);
		chk(q, 32'hFFFF_FFFF, 32'h0000_00FB);
		exec(16'hE8C1);
		chk(q, 32'h0004_3000, 32'h0000_2000);
		exec(16'hE9C2);
		rd(8'h1C);
		chk(q, 32'hFFFF_FFFF, 32'h0000_0421);
		chk(32'(pops), 32'hFFFF_FFFF, 32'h0000_0002);
		exec(16'hEA00);
		chk(q, 32'h0004_0000, 32'h0004_0000);
		bus(1'b1, 8'h04, 32'h0000_0000);
		exec(16'hE8A3);
		rd(8'h1C);
		chk(q, 32'hFFFF_FFFF, 32'h0000_0421);
	endtask : t_ext
	initial begin
		hresetn = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		num_errors = 0;
		num_checks = 0;
		pops = 0;
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'h00;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_xor_literal_acc();
		t_xor_acc_with_file();
		t_indexed();
		t_skip();
		t_ext();
		stop_test();
	end
endmodule : cpu_test_xor_and_ext_set_tb
`default_nettype wire
